/* File: include/dcdc_ctrl_map.vh */
// Register map, field positions and reset values for the converter control block
`ifndef DCDC_CTRL_MAP_VH
`define DCDC_CTRL_MAP_VH

// Register offsets (byte addresses on the register port)
`define OFS_ACTIVE_OPTIONS 8'hB1
`define OFS_LDO_OPTIONS 8'hB2
`define OFS_BUCK1_VOLTAGE 8'hB4
`define OFS_BUCK1_LOW_POWER 8'hB6
`define OFS_BOOST_CONTROL 8'hB7
`define OFS_BUCK3_VOLTAGE 8'hBA
`define OFS_BUCK3_LOW_POWER 8'hBC
`define OFS_BUCK4_VOLTAGE 8'hBD
`define OFS_BUCK4_LOW_POWER 8'hBF
`define OFS_ENABLE_CONTROL 8'hC0
`define OFS_SINK_CURRENT 8'hC1
`define OFS_STATUS 8'hC2

// Select bit positions inside the active and low-dropout option registers
`define POS_SEL_BUCK1 0
`define POS_SEL_BUCK3 2
`define POS_SEL_BUCK4 3

// Voltage control register fields
`define MSB_VOLTAGE_CODE 6
`define POS_FLOAT_SELECT 10

// Low-power control register fields
`define MSB_ALT_CODE 6
`define MSB_TRIGGER 9
`define LSB_TRIGGER 8
`define MSB_BEHAVIOUR 14
`define LSB_BEHAVIOUR 12

// Boost control register fields
`define POS_BOOST_MODE 14
`define MSB_RAMP 4
`define LSB_RAMP 3
`define MSB_FEEDBACK 1
`define LSB_FEEDBACK 0

// Enable control register fields
`define POS_EN_BUCK1 0
`define POS_EN_BOOST 1
`define POS_EN_BUCK3 2
`define POS_EN_BUCK4 3
`define POS_LOW_POWER_REG 8

// Codes
`define CODE_MAX_VOLTAGE 7'h66
`define MODE_STANDBY 2'h0
`define MODE_ACTIVE 2'h1
`define MODE_LDO 2'h2
`define FB_EXTERNAL 2'h0
`define FB_SINK 2'h1
`define FB_INTERNAL 2'h3
`define RAMP_UPTO_5V 2'h3

// Reset values
`define RST_VOLTAGE_CODE 7'h06
`define RST_ALT_CODE 7'h06
`define RST_BEHAVIOUR 3'h1
`define RST_TRIGGER 2'h0
`define RST_ACTIVE_SEL 1'h1
`define RST_LDO_SEL 1'h0
`define RST_RAMP 2'h1
`define RST_FEEDBACK 2'h0
`define RST_SINK_CURRENT 6'h00

`endif

/* File: rtl/dcdc_voltage_mode_control.v */
// Digital mode and voltage control for three buck converters and one boost converter
//
// Operation
// - Buck code is 0.85 V plus 25 mV steps
// - Buck codes above 0x66 clamp at 3.4 V
// - Alternate code, same encoding, resets to 1.0 V
// - Disabled buck discharges unless float bit set
// - No request or 000/001: normal selects; 001 alternate
// - Request 010/011 standby, 100/101 low-dropout
// - Request with 110/111 disables the converter
// - Request is low-power pin or triggered source
// - Same resolution per buck, gated by enable
// - Switch mode: pass switch follows boost enable
// - Feedback 00 uses external divider
// - Feedback 01 regulates LED sink current
// - Feedback 11 gives fixed 5 V internally
// - Current feedback in boost mode: external divider limits voltage
// - Ramp pair encodes four output ranges
// - Boost mode bit: 0 boost, 1 switch
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "dcdc_ctrl_map.vh"

// Per-converter mode and voltage resolution, registered outputs
module buck_resolve (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire enable_i,
    input wire low_power_req_i,
    input wire [2:0] behaviour_i,
    input wire ldo_sel_i,
    input wire active_sel_i,
    input wire float_sel_i,
    input wire [6:0] voltage_code_i,
    input wire [6:0] alt_code_i,
    output reg regulate_o,
    output reg [1:0] mode_o,
    output reg [6:0] voltage_o,
    output reg discharge_o
);
    reg [1:0] next_mode;
    reg use_alt;
    reg lp_off;
    reg [6:0] chosen;

    // Mode and voltage choice from request and behaviour code
    always @* begin
        next_mode = ldo_sel_i ? `MODE_LDO : (active_sel_i ? `MODE_ACTIVE : `MODE_STANDBY);
        use_alt = 1'b0;
        lp_off = 1'b0;
        if (low_power_req_i) begin
            case (behaviour_i)
                3'h0: use_alt = 1'b0;
                3'h1: use_alt = 1'b1;
                3'h2: next_mode = `MODE_STANDBY;
                3'h3: begin
                    next_mode = `MODE_STANDBY;
                    use_alt = 1'b1;
                end
                3'h4: next_mode = `MODE_LDO;
                3'h5: begin
                    next_mode = `MODE_LDO;
                    use_alt = 1'b1;
                end
                default: lp_off = 1'b1;
            endcase
        end
        chosen = use_alt ? alt_code_i : voltage_code_i;
    end

    // Outputs follow settings each cycle, so code changes need no disable
    always @(posedge clk_i) begin
        if (srst_i) begin
            regulate_o <= 1'b0;
            mode_o <= `MODE_STANDBY;
            voltage_o <= 7'h00;
            discharge_o <= 1'b0;
        end else if (ce_i) begin
            regulate_o <= enable_i & ~lp_off;
            mode_o <= next_mode;
            // Codes past the top step add nothing
            voltage_o <= (chosen > `CODE_MAX_VOLTAGE) ? `CODE_MAX_VOLTAGE : chosen;
            discharge_o <= ~(enable_i & ~lp_off) & ~float_sel_i;
        end
    end
endmodule

module dcdc_voltage_mode_control (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [15:0] rdata_o,
    input wire low_power_pin_i,
    input wire [2:0] low_power_line_i,
    output wire [2:0] buck_regulate_o,
    output wire [5:0] buck_mode_o,
    output wire [20:0] buck_voltage_o,
    output wire [2:0] buck_discharge_o,
    output reg boost_switch_closed_o,
    output reg boost_regulate_o,
    output reg [1:0] boost_feedback_o,
    output reg boost_ext_limit_o,
    output reg [1:0] boost_ramp_o,
    output reg [5:0] sink_current_o
);
    // Arbitrary power-up voltage code; real parts strap this
    parameter [6:0] VOLTAGE_RESET = `RST_VOLTAGE_CODE;

    // Buck settings, index 0/1/2 = converters 1/3/4
    reg [6:0] voltage_code [0:2];
    reg [6:0] alt_code [0:2];
    reg [2:0] float_sel;
    reg [2:0] behaviour [0:2];
    reg [1:0] trigger_sel [0:2];
    reg [2:0] active_sel;
    reg [2:0] ldo_sel;
    reg [2:0] buck_enable;
    reg low_power_reg;

    // Boost settings
    reg boost_enable;
    reg boost_mode;
    reg [1:0] ramp;
    reg [1:0] feedback;
    reg [5:0] sink_current;

    // Pin synchronisers: three stages, change taken when stages two and three agree
    reg [3:0] pin_s1;
    reg [3:0] pin_s2;
    reg [3:0] pin_s3;
    reg [3:0] pin_stable;
    wire [3:0] pins_now;
    wire [3:0] pins_agree;

    reg [2:0] low_power_req;
    reg [15:0] next_rdata;
    integer i, j;

    assign pins_now = {low_power_line_i, low_power_pin_i};
    assign pins_agree = ~(pin_s2 ^ pin_s3);

    // Asynchronous pins cross here; stage one feeds only stage two
    always @(posedge clk_i) begin
        if (srst_i) begin
            pin_s1 <= 4'h0;
            pin_s2 <= 4'h0;
            pin_s3 <= 4'h0;
            pin_stable <= 4'h0;
        end else if (ce_i) begin
            pin_s1 <= pins_now;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_stable <= (pin_s2 & pins_agree) | (pin_stable & ~pins_agree);
        end
    end

    // Low-power request per converter: global pin or selected source
    always @* begin
        for (i = 0; i < 3; i = i + 1) begin
            case (trigger_sel[i])
                2'h0: low_power_req[i] = pin_stable[0] | low_power_reg;
                2'h1: low_power_req[i] = pin_stable[0] | pin_stable[1];
                2'h2: low_power_req[i] = pin_stable[0] | pin_stable[2];
                default: low_power_req[i] = pin_stable[0] | pin_stable[3];
            endcase
        end
    end

    // Register writes; every field holds what was last written
    always @(posedge clk_i) begin
        if (srst_i) begin
            for (j = 0; j < 3; j = j + 1) begin
                voltage_code[j] <= VOLTAGE_RESET;
                alt_code[j] <= `RST_ALT_CODE;
                behaviour[j] <= `RST_BEHAVIOUR;
                trigger_sel[j] <= `RST_TRIGGER;
            end
            float_sel <= 3'h0;
            active_sel <= {3{`RST_ACTIVE_SEL}};
            ldo_sel <= {3{`RST_LDO_SEL}};
            buck_enable <= 3'h0;
            low_power_reg <= 1'b0;
            boost_enable <= 1'b0;
            boost_mode <= 1'b0;
            ramp <= `RST_RAMP;
            feedback <= `RST_FEEDBACK;
            sink_current <= `RST_SINK_CURRENT;
        end else if (ce_i && wr_i) begin
            case (addr_i)
                `OFS_ACTIVE_OPTIONS: begin
                    active_sel <= {wdata_i[`POS_SEL_BUCK4], wdata_i[`POS_SEL_BUCK3], wdata_i[`POS_SEL_BUCK1]};
                end
                `OFS_LDO_OPTIONS: begin
                    ldo_sel <= {wdata_i[`POS_SEL_BUCK4], wdata_i[`POS_SEL_BUCK3], wdata_i[`POS_SEL_BUCK1]};
                end
                `OFS_BUCK1_VOLTAGE: begin
                    voltage_code[0] <= wdata_i[`MSB_VOLTAGE_CODE:0];
                    float_sel[0] <= wdata_i[`POS_FLOAT_SELECT];
                end
                `OFS_BUCK3_VOLTAGE: begin
                    voltage_code[1] <= wdata_i[`MSB_VOLTAGE_CODE:0];
                    float_sel[1] <= wdata_i[`POS_FLOAT_SELECT];
                end
                `OFS_BUCK4_VOLTAGE: begin
                    voltage_code[2] <= wdata_i[`MSB_VOLTAGE_CODE:0];
                    float_sel[2] <= wdata_i[`POS_FLOAT_SELECT];
                end
                `OFS_BUCK1_LOW_POWER: begin
                    alt_code[0] <= wdata_i[`MSB_ALT_CODE:0];
                    trigger_sel[0] <= wdata_i[`MSB_TRIGGER:`LSB_TRIGGER];
                    behaviour[0] <= wdata_i[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR];
                end
                `OFS_BUCK3_LOW_POWER: begin
                    alt_code[1] <= wdata_i[`MSB_ALT_CODE:0];
                    trigger_sel[1] <= wdata_i[`MSB_TRIGGER:`LSB_TRIGGER];
                    behaviour[1] <= wdata_i[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR];
                end
                `OFS_BUCK4_LOW_POWER: begin
                    alt_code[2] <= wdata_i[`MSB_ALT_CODE:0];
                    trigger_sel[2] <= wdata_i[`MSB_TRIGGER:`LSB_TRIGGER];
                    behaviour[2] <= wdata_i[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR];
                end
                `OFS_BOOST_CONTROL: begin
                    boost_mode <= wdata_i[`POS_BOOST_MODE];
                    ramp <= wdata_i[`MSB_RAMP:`LSB_RAMP];
                    feedback <= wdata_i[`MSB_FEEDBACK:`LSB_FEEDBACK];
                end
                `OFS_ENABLE_CONTROL: begin
                    buck_enable <= {wdata_i[`POS_EN_BUCK4], wdata_i[`POS_EN_BUCK3], wdata_i[`POS_EN_BUCK1]};
                    boost_enable <= wdata_i[`POS_EN_BOOST];
                    low_power_reg <= wdata_i[`POS_LOW_POWER_REG];
                end
                `OFS_SINK_CURRENT: begin
                    sink_current <= wdata_i[5:0];
                end
                default: begin
                    sink_current <= sink_current;
                end
            endcase
        end
    end

    // Identical resolution for each buck converter
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : bucks
            buck_resolve u_resolve (
                .clk_i(clk_i),
                .srst_i(srst_i),
                .ce_i(ce_i),
                .enable_i(buck_enable[g]),
                .low_power_req_i(low_power_req[g]),
                .behaviour_i(behaviour[g]),
                .ldo_sel_i(ldo_sel[g]),
                .active_sel_i(active_sel[g]),
                .float_sel_i(float_sel[g]),
                .voltage_code_i(voltage_code[g]),
                .alt_code_i(alt_code[g]),
                .regulate_o(buck_regulate_o[g]),
                .mode_o(buck_mode_o[2*g+1:2*g]),
                .voltage_o(buck_voltage_o[7*g+6:7*g]),
                .discharge_o(buck_discharge_o[g])
            );
        end
    endgenerate

    // Boost converter control; ramp is software's to match, except fixed 5 V output
    always @(posedge clk_i) begin
        if (srst_i) begin
            boost_switch_closed_o <= 1'b0;
            boost_regulate_o <= 1'b0;
            boost_feedback_o <= `FB_EXTERNAL;
            boost_ext_limit_o <= 1'b0;
            boost_ramp_o <= `RST_RAMP;
            sink_current_o <= `RST_SINK_CURRENT;
        end else if (ce_i) begin
            boost_switch_closed_o <= boost_mode & boost_enable;
            boost_regulate_o <= ~boost_mode & boost_enable;
            boost_feedback_o <= feedback;
            boost_ext_limit_o <= ~boost_mode & (feedback == `FB_SINK);
            boost_ramp_o <= (feedback == `FB_INTERNAL) ? `RAMP_UPTO_5V : ramp;
            sink_current_o <= sink_current;
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always @* begin
        next_rdata = 16'h0000;
        case (addr_i)
            `OFS_ACTIVE_OPTIONS: begin
                next_rdata[`POS_SEL_BUCK1] = active_sel[0];
                next_rdata[`POS_SEL_BUCK3] = active_sel[1];
                next_rdata[`POS_SEL_BUCK4] = active_sel[2];
            end
            `OFS_LDO_OPTIONS: begin
                next_rdata[`POS_SEL_BUCK1] = ldo_sel[0];
                next_rdata[`POS_SEL_BUCK3] = ldo_sel[1];
                next_rdata[`POS_SEL_BUCK4] = ldo_sel[2];
            end
            `OFS_BUCK1_VOLTAGE: begin
                next_rdata[`MSB_VOLTAGE_CODE:0] = voltage_code[0];
                next_rdata[`POS_FLOAT_SELECT] = float_sel[0];
            end
            `OFS_BUCK3_VOLTAGE: begin
                next_rdata[`MSB_VOLTAGE_CODE:0] = voltage_code[1];
                next_rdata[`POS_FLOAT_SELECT] = float_sel[1];
            end
            `OFS_BUCK4_VOLTAGE: begin
                next_rdata[`MSB_VOLTAGE_CODE:0] = voltage_code[2];
                next_rdata[`POS_FLOAT_SELECT] = float_sel[2];
            end
            `OFS_BUCK1_LOW_POWER: begin
                next_rdata[`MSB_ALT_CODE:0] = alt_code[0];
                next_rdata[`MSB_TRIGGER:`LSB_TRIGGER] = trigger_sel[0];
                next_rdata[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR] = behaviour[0];
            end
            `OFS_BUCK3_LOW_POWER: begin
                next_rdata[`MSB_ALT_CODE:0] = alt_code[1];
                next_rdata[`MSB_TRIGGER:`LSB_TRIGGER] = trigger_sel[1];
                next_rdata[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR] = behaviour[1];
            end
            `OFS_BUCK4_LOW_POWER: begin
                next_rdata[`MSB_ALT_CODE:0] = alt_code[2];
                next_rdata[`MSB_TRIGGER:`LSB_TRIGGER] = trigger_sel[2];
                next_rdata[`MSB_BEHAVIOUR:`LSB_BEHAVIOUR] = behaviour[2];
            end
            `OFS_BOOST_CONTROL: begin
                next_rdata[`POS_BOOST_MODE] = boost_mode;
                next_rdata[`MSB_RAMP:`LSB_RAMP] = ramp;
                next_rdata[`MSB_FEEDBACK:`LSB_FEEDBACK] = feedback;
            end
            `OFS_ENABLE_CONTROL: begin
                next_rdata[`POS_EN_BUCK1] = buck_enable[0];
                next_rdata[`POS_EN_BOOST] = boost_enable;
                next_rdata[`POS_EN_BUCK3] = buck_enable[1];
                next_rdata[`POS_EN_BUCK4] = buck_enable[2];
                next_rdata[`POS_LOW_POWER_REG] = low_power_reg;
            end
            `OFS_SINK_CURRENT: begin
                next_rdata[5:0] = sink_current;
            end
            // Live state: regulate flags, requests, boost switch state
            `OFS_STATUS: begin
                next_rdata[2:0] = buck_regulate_o;
                next_rdata[5:3] = low_power_req;
                next_rdata[6] = boost_switch_closed_o;
                next_rdata[7] = boost_regulate_o;
                next_rdata[13:8] = buck_mode_o;
            end
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 16'h0000;
        end else if (ce_i) begin
            rdata_o <= rd_i ? next_rdata : 16'h0000;
        end
    end
endmodule

/* File: test/dcdc_voltage_mode_control_chk.sv */
// Port-level checker for the converter mode and voltage control block
`timescale 1ns/1ps
`include "dcdc_ctrl_map.vh"
module dcdc_ctrl_chk (
    input wire clk_i,
    input wire srst_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [15:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [15:0] rdata_o,
    input wire [2:0] buck_regulate_o,
    input wire [5:0] buck_mode_o,
    input wire [20:0] buck_voltage_o,
    input wire [2:0] buck_discharge_o,
    input wire boost_switch_closed_o,
    input wire boost_regulate_o,
    input wire [1:0] boost_feedback_o,
    input wire boost_ext_limit_o,
    input wire [1:0] boost_ramp_o,
    input wire [5:0] sink_current_o
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    // Read data stands only in the cycle after a read
    a_rdata_idle: assert property ($past(ce_i) && !$past(rd_i) |-> rdata_o == 16'h0000)
        else $error("read data not zero outside a read answer");
    a_volt_clamp: assert property (buck_voltage_o[6:0] <= 7'h66 && buck_voltage_o[13:7] <= 7'h66
        && buck_voltage_o[20:14] <= 7'h66) else $error("buck voltage code above ceiling");
    a_mode_legal: assert property (buck_mode_o[1:0] != 2'h3 && buck_mode_o[3:2] != 2'h3
        && buck_mode_o[5:4] != 2'h3) else $error("buck mode code undefined");
    a_discharge_off: assert property ((buck_discharge_o & buck_regulate_o) == 3'h0)
        else $error("discharge while regulating");
    a_switch_excl: assert property (!(boost_switch_closed_o && boost_regulate_o))
        else $error("boost switch and regulation together");
    a_ext_limit: assert property (boost_ext_limit_o |-> boost_feedback_o == 2'h1 && !boost_switch_closed_o)
        else $error("external limit without current feedback");
    a_ramp_forced: assert property (boost_feedback_o == 2'h3 |-> boost_ramp_o == 2'h3)
        else $error("ramp not forced for internal divider");
    // Output follows a sink write two edges later
    a_sink_write: assert property ((ce_i && wr_i && addr_i == `OFS_SINK_CURRENT) ##1 ce_i ##1 ce_i
        |-> sink_current_o == $past(wdata_i[5:0], 2)) else $error("sink current not applied");
    // Reads right after a write or a frozen cycle are skipped: the output stage lags one edge
    a_sink_read: assert property (ce_i && rd_i && addr_i == `OFS_SINK_CURRENT && $past(ce_i) && !$past(wr_i)
        |=> rdata_o[5:0] == $past(sink_current_o)) else $error("sink readback mismatch");
    // Clock enable low must hold read data, buck voltage codes and sink current
    a_ce_freeze: assert property (!ce_i |=> $stable(rdata_o) && $stable(buck_voltage_o) && $stable(sink_current_o))
        else $error("outputs moved while clock enable low");
endmodule

bind dcdc_voltage_mode_control dcdc_ctrl_chk u_chk (.clk_i, .srst_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .buck_regulate_o, .buck_mode_o, .buck_voltage_o, .buck_discharge_o, .boost_switch_closed_o,
    .boost_regulate_o, .boost_feedback_o, .boost_ext_limit_o, .boost_ramp_o, .sink_current_o);

/* File: test/tb_top.sv */
// Self-checking bench for the converter mode and voltage control block
`timescale 1ns/1ps
`include "dcdc_ctrl_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top;
    reg clk_i = 1'b0;
    reg srst_i = 1'b1;
    reg ce_i = 1'b1;
    reg [7:0] addr_i = 8'h00;
    reg [15:0] wdata_i = 16'h0000;
    reg wr_i = 1'b0;
    reg rd_i = 1'b0;
    reg lp_pin = 1'b0;
    reg [2:0] lp_line = 3'h0;
    reg [9:0] exp_res;
    wire [15:0] rdata_o;
    wire [2:0] b_reg;
    wire [5:0] b_mode;
    wire [20:0] b_volt;
    wire [2:0] b_dis;
    wire sw_closed, bst_reg, ext_lim;
    wire [1:0] fb, ramp;
    wire [5:0] sink;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int r, l, c;

    dcdc_voltage_mode_control dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .low_power_pin_i(lp_pin),
        .low_power_line_i(lp_line), .buck_regulate_o(b_reg), .buck_mode_o(b_mode), .buck_voltage_o(b_volt),
        .buck_discharge_o(b_dis), .boost_switch_closed_o(sw_closed), .boost_regulate_o(bst_reg),
        .boost_feedback_o(fb), .boost_ext_limit_o(ext_lim), .boost_ramp_o(ramp), .sink_current_o(sink));

    // 40 MHz clock
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    task wrap_up;
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            wrap_up;
        end
    end

    task wr(input [7:0] a, input [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // Read answer is looked at in the one cycle it stands
    task rchk(input [7:0] a, input [15:0] e);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
    endtask

    task settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Pins pass a synchroniser, so allow six edges
    task pins(input p, input [2:0] ln);
        @(posedge clk_i);
        lp_pin <= p;
        lp_line <= ln;
        settle(6);
    endtask

    // Buck1 with active select 1, primary 0x40, alternate 0x20
    function [9:0] expect_res(input req, input [2:0] cd, input ldo);
        reg [1:0] m;
        begin
            m = (!req || cd < 3'h2) ? (ldo ? 2'h2 : 2'h1) : (cd < 3'h4 ? 2'h0 : 2'h2);
            expect_res = {!(req && cd > 3'h5), m, (req && cd[0]) ? 7'h20 : 7'h40};
        end
    endfunction

    initial begin
        repeat (5) @(posedge clk_i);
        srst_i <= 1'b0;
        settle(3);
        `CHK(b_mode, 6'h15)
        `CHK(b_volt, {3{7'h06}})
        `CHK(b_dis, 3'h7)
        `CHK(ramp, 2'h1)
        rchk(`OFS_BUCK1_VOLTAGE, 16'h0006);
        rchk(`OFS_BUCK3_LOW_POWER, 16'h1006);
        rchk(`OFS_ACTIVE_OPTIONS, 16'h000D);
        rchk(`OFS_BOOST_CONTROL, 16'h0008);
        rchk(8'h10, 16'h0000);
        // Clamp at the ceiling and float versus discharge
        wr(`OFS_ENABLE_CONTROL, 16'h000D);
        wr(`OFS_BUCK1_VOLTAGE, 16'h007F);
        settle(3);
        `CHK(b_reg, 3'h7)
        `CHK(b_dis, 3'h0)
        `CHK(b_volt[6:0], 7'h66)
        rchk(`OFS_BUCK1_VOLTAGE, 16'h007F);
        wr(`OFS_BUCK1_VOLTAGE, 16'h0466);
        wr(`OFS_ENABLE_CONTROL, 16'h0008);
        settle(3);
        `CHK(b_dis, 3'h2)
        `CHK(b_reg, 3'h4)
        // Every behaviour code, request off and on, low-dropout off and on
        wr(`OFS_BUCK1_VOLTAGE, 16'h0040);
        for (r = 0; r < 2; r++)
            for (l = 0; l < 2; l++) begin
                wr(`OFS_LDO_OPTIONS, {15'h0, l[0]});
                for (c = 0; c < 8; c++) begin
                    wr(`OFS_ENABLE_CONTROL, {7'h0, r[0], 8'h0D});
                    wr(`OFS_BUCK1_LOW_POWER, {1'b0, c[2:0], 12'h020});
                    settle(3);
                    exp_res = expect_res(r[0], c[2:0], l[0]);
                    `CHK(b_reg[0], exp_res[9])
                    if (exp_res[9]) begin
                        `CHK(b_mode[1:0], exp_res[8:7])
                        `CHK(b_volt[6:0], exp_res[6:0])
                    end
                end
            end
        wr(`OFS_ENABLE_CONTROL, 16'h000D);
        wr(`OFS_LDO_OPTIONS, 16'h0000);
        wr(`OFS_ACTIVE_OPTIONS, 16'h0000);
        settle(3);
        `CHK(b_mode, 6'h00)
        // Trigger lines and the global low-power pin
        wr(`OFS_BUCK3_LOW_POWER, 16'h7106);
        wr(`OFS_BUCK1_LOW_POWER, 16'h7006);
        wr(`OFS_BUCK4_VOLTAGE, 16'h0030);
        pins(1'b0, 3'h1);
        `CHK(b_reg, 3'h5)
        pins(1'b0, 3'h6);
        `CHK(b_reg, 3'h7)
        pins(1'b1, 3'h0);
        `CHK(b_reg, 3'h4)
        `CHK(b_volt[20:14], 7'h06)
        rchk(`OFS_STATUS, 16'h003C);
        pins(1'b0, 3'h0);
        // Boost switch mode then feedback sources
        wr(`OFS_BOOST_CONTROL, 16'h4008);
        wr(`OFS_ENABLE_CONTROL, 16'h0002);
        settle(3);
        `CHK({sw_closed, bst_reg}, 2'h2)
        wr(`OFS_ENABLE_CONTROL, 16'h0000);
        settle(3);
        `CHK({sw_closed, bst_reg}, 2'h0)
        wr(`OFS_ENABLE_CONTROL, 16'h0002);
        wr(`OFS_BOOST_CONTROL, 16'h0011);
        settle(3);
        `CHK({sw_closed, bst_reg, fb, ext_lim, ramp}, 7'h2E)
        wr(`OFS_BOOST_CONTROL, 16'h0003);
        settle(3);
        `CHK({sw_closed, bst_reg, fb, ext_lim, ramp}, 7'h3B)
        wr(`OFS_BOOST_CONTROL, 16'h0010);
        settle(3);
        `CHK({sw_closed, bst_reg, fb, ext_lim, ramp}, 7'h22)
        wr(`OFS_SINK_CURRENT, 16'h002A);
        settle(3);
        `CHK(sink, 6'h2A)
        rchk(`OFS_SINK_CURRENT, 16'h002A);
        // Clock enable low: a write is ignored and outputs hold
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(`OFS_SINK_CURRENT, 16'h0015);
        settle(3);
        `CHK(sink, 6'h2A)
        @(posedge clk_i);
        ce_i <= 1'b1;
        rchk(`OFS_SINK_CURRENT, 16'h002A);
        // Reset in mid-run brings back the power-up settings
        @(posedge clk_i);
        srst_i <= 1'b1;
        @(posedge clk_i);
        srst_i <= 1'b0;
        settle(3);
        `CHK(b_volt, {3{7'h06}})
        `CHK(sink, 6'h00)
        rchk(`OFS_BUCK1_LOW_POWER, 16'h1006);
        wrap_up;
    end
endmodule
